// file: hdl/tmo_pkg.sv
// package for the sixteen-bit timer one block: map, fields, carriers
package tmo_pkg;

  // avalon slave widths; address is a byte address
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int REG_W = 8;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_CNT_LO = 8'h0e;
  localparam logic [7:0] IDX_CNT_HI = 8'h0f;
  localparam logic [7:0] IDX_CTRL = 8'h10;
  localparam logic [7:0] IDX_ENABLES = 8'h8c;

  // timer_one_control field positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SRC = 1;
  localparam int CTRL_SYNC = 2;
  localparam int CTRL_OSC = 3;
  localparam int CTRL_PS_LO = 4;
  localparam int CTRL_PS_HI = 5;
  localparam logic [7:0] CTRL_MASK = 8'h3f;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // interrupt flag and enable layout
  localparam int IRQ_OVF_BIT = 0;
  localparam logic [7:0] FLAGS_MASK = 8'h01;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;

  // count and prescaler constants
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_CLR = 16'h0000;
  localparam int PRE_W = 3;
  localparam int IDIV_W = 8;

  // avalon request bundle from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [BE_W-1:0] byteenable;
  } tmo_avs_req_t;

  // whole state of the timer block
  typedef struct packed {
    logic ack;
    logic wreq;
    logic [REG_W-1:0] rdata;
    logic [REG_W-1:0] ctrl;
    logic [15:0] count;
    logic [PRE_W-1:0] pre;
    logic [IDIV_W-1:0] idiv;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic flag;
    logic en;
    logic irq;
  } tmo_state_t;

endpackage

// file: hdl/tmo_timer.sv
// sixteen-bit timer one with prescaler, overflow irq, avalon-mm slave
//
// Function
// - power-on reset clears control register to zero
// - other resets keep control register unchanged
// - count byte writes clear the prescaler
// - low count byte readable, writable, kept
// - high count byte readable, writable, kept
// - control upper two bits read zero
// - compare trigger resets the sixteen-bit count
// - count write beats a coincident trigger
// - trigger reset never sets overflow flag
// - oscillator enable bit drives crystal enable
//
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps

module tmo_timer
  import tmo_pkg::*;
#(
  parameter int INSTR_DIV = 4
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic soft_rst_n_i,
  input wire tmo_avs_req_t avs_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic ext_clk_i,
  input wire logic cmp_trig_a_i,
  input wire logic cmp_trig_b_i,
  output logic crystal_osc_enable_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // word index of a byte address
  function automatic logic [7:0] reg_idx(
    input logic [ADDR_W-1:0] a
  );
    reg_idx = a[ADDR_W-1:2];
  endfunction

  // prescaler wrap mask for ratios 1, 2, 4, 8
  function automatic logic [PRE_W-1:0] pre_mask(
    input logic [1:0] sel
  );
    logic [PRE_W-1:0] m;
    m = '0;
    if (sel == 2'h1) begin
      m = 3'h1;
    end else if (sel == 2'h2) begin
      m = 3'h3;
    end else if (sel == 2'h3) begin
      m = 3'h7;
    end
    pre_mask = m;
  endfunction

  localparam logic [IDIV_W-1:0] IDIV_LAST = IDIV_W'(INSTR_DIV - 1);

  ////////////////////////////////////////////////////////////////////
  // state

  tmo_state_t st;
  tmo_state_t next_st;

  logic req;
  logic take;
  logic commit;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic wr_lo;
  logic wr_hi;
  logic wr_cnt;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_en;
  logic trig;
  logic run;
  logic int_tick;
  logic ext_tick;
  logic src_tick;
  logic pre_wrap;
  logic inc;
  logic ovf;
  logic [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////
  // bus decode

  // a request is taken on the first edge, committed on the second
  always_comb begin
    req = avs_i.read | avs_i.write;
    take = req & ~st.ack & soft_rst_n_i;
    commit = req & st.ack;
    idx = reg_idx(avs_i.address);
    wbyte = avs_i.writedata[7:0];
    wr = commit & avs_i.write & avs_i.byteenable[0] & soft_rst_n_i;
    wr_lo = 1'b0;
    wr_hi = 1'b0;
    wr_ctrl = 1'b0;
    wr_flags = 1'b0;
    wr_en = 1'b0;
    if (idx == IDX_CNT_LO) begin
      wr_lo = wr;
    end else if (idx == IDX_CNT_HI) begin
      wr_hi = wr;
    end else if (idx == IDX_CTRL) begin
      wr_ctrl = wr;
    end else if (idx == IDX_FLAGS) begin
      wr_flags = wr;
    end else if (idx == IDX_ENABLES) begin
      wr_en = wr;
    end
    wr_cnt = wr_lo | wr_hi;
  end

  // read mux; unmapped words and absent bits read zero
  always_comb begin
    rd_mux = '0;
    if (idx == IDX_CNT_LO) begin
      rd_mux = st.count[7:0];
    end else if (idx == IDX_CNT_HI) begin
      rd_mux = st.count[15:8];
    end else if (idx == IDX_CTRL) begin
      rd_mux = st.ctrl & CTRL_MASK;
    end else if (idx == IDX_FLAGS) begin
      rd_mux = {7'h00, st.flag};
    end else if (idx == IDX_ENABLES) begin
      rd_mux = {7'h00, st.en};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // count sources

  // the pin is sampled twice before use; edge taken after second flop
  always_comb begin
    run = st.ctrl[CTRL_RUN];
    trig = cmp_trig_a_i | cmp_trig_b_i;
    int_tick = (st.idiv == IDIV_LAST);
    ext_tick = st.ext_sync[1] & ~st.ext_prev;
    src_tick = st.ctrl[CTRL_SRC] ? ext_tick : int_tick;
    pre_wrap = (st.pre & pre_mask(st.ctrl[CTRL_PS_HI:CTRL_PS_LO]))
               == pre_mask(st.ctrl[CTRL_PS_HI:CTRL_PS_LO]);
    inc = run & src_tick & pre_wrap;
    ovf = inc & ~wr_cnt & ~trig & (st.count == COUNT_MAX);
  end

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    // handshake: waitrequest drops for exactly the commit cycle
    next_st.ack = take;
    next_st.wreq = ~take;
    if (take) begin
      next_st.rdata = rd_mux;
    end
    // pin synchroniser and edge history
    next_st.ext_sync = {st.ext_sync[0], ext_clk_i};
    next_st.ext_prev = st.ext_sync[1];
    // instruction clock divider runs free
    next_st.idiv = int_tick ? '0 : st.idiv + 1'b1;
    // prescaler steps on each source tick while running
    if (run & src_tick) begin
      next_st.pre = pre_wrap ? '0 : st.pre + 1'b1;
    end
    // control register, upper bits never stored
    if (wr_ctrl) begin
      next_st.ctrl = wbyte & CTRL_MASK;
    end
    // count: write beats trigger beats increment
    if (wr_cnt) begin
      if (wr_lo) begin
        next_st.count[7:0] = wbyte;
      end
      if (wr_hi) begin
        next_st.count[15:8] = wbyte;
      end
      next_st.pre = '0;
    end else if (trig) begin
      next_st.count = COUNT_CLR;
    end else if (inc) begin
      next_st.count = st.count + 16'h0001;
    end
    // sticky flag: set wins over write-one-to-clear
    next_st.flag = (st.flag & ~(wr_flags & wbyte[IRQ_OVF_BIT]))
                   | ovf;
    if (wr_en) begin
      next_st.en = wbyte[IRQ_OVF_BIT];
    end
    // warm reset keeps control and count, clears handshake, prescaler, divider, flag and enable
    if (!soft_rst_n_i) begin
      next_st.ack = 1'b0;
      next_st.wreq = 1'b1;
      next_st.pre = '0;
      next_st.idiv = '0;
      next_st.flag = FLAGS_RST[IRQ_OVF_BIT];
      next_st.en = EN_RST[IRQ_OVF_BIT];
      next_st.ctrl = st.ctrl;
      next_st.count = st.count;
    end
    next_st.irq = next_st.flag & next_st.en;
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  // power-on reset; the count is undefined there, zero is chosen
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st.ack <= 1'b0;
      st.wreq <= 1'b1;
      st.rdata <= 8'h00;
      st.ctrl <= CTRL_RST;
      st.count <= COUNT_CLR;
      st.pre <= '0;
      st.idiv <= '0;
      st.ext_sync <= 2'h0;
      st.ext_prev <= 1'b0;
      st.flag <= 1'b0;
      st.en <= 1'b0;
      st.irq <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign avs_readdata_o = {24'h00_0000, st.rdata};
  assign avs_waitrequest_o = st.wreq;
  assign crystal_osc_enable_o = st.ctrl[CTRL_OSC];
  assign irq_o = st.irq;

  ////////////////////////////////////////////////////////////////////
  // checks

  // marks the first cycle after power-on reset release
  logic seen;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seen <= 1'b0;
    end else begin
      seen <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_ctrl_por_zero: assert property (
    !seen |-> st.ctrl == CTRL_RST && !crystal_osc_enable_o
  ) else $error("control not zero after power-on reset");

  a_ctrl_warm_kept: assert property (
    !soft_rst_n_i |=> st.ctrl == $past(st.ctrl)
                      && st.count == $past(st.count)
  ) else $error("warm reset changed control or count");

  a_pre_write_clr: assert property (
    wr_cnt |=> st.pre == '0
  ) else $error("prescaler not cleared by count write");

  a_cnt_lo_write: assert property (
    wr_lo && !wr_hi |=> st.count[7:0] == $past(wbyte)
                        && st.count[15:8] == $past(st.count[15:8])
  ) else $error("low count byte write lost");

  a_cnt_hi_write: assert property (
    wr_hi |=> st.count[15:8] == $past(wbyte)
              && st.count[7:0] == $past(st.count[7:0])
  ) else $error("high count byte write lost");

  a_ctrl_top_zero: assert property (
    take && avs_i.read && idx == IDX_CTRL
    |=> !avs_waitrequest_o && avs_readdata_o[7:6] == 2'h0
        && avs_readdata_o[5:0] == $past(st.ctrl[5:0])
  ) else $error("control read shows upper bits or stale data");

  a_trig_cnt_clr: assert property (
    trig && !wr_cnt && soft_rst_n_i |=> st.count == COUNT_CLR
  ) else $error("trigger did not clear count");

  a_write_beats_trig: assert property (
    trig && wr_lo |=> st.count[7:0] == $past(wbyte)
  ) else $error("trigger overrode count write");

  a_trig_no_flag: assert property (
    trig && !st.flag && soft_rst_n_i |=> !st.flag
  ) else $error("trigger reset set the overflow flag");

  a_osc_follows: assert property (
    wr_ctrl |=> crystal_osc_enable_o == $past(wbyte[CTRL_OSC])
  ) else $error("crystal enable does not follow control");

  a_roll_flag: assert property (
    inc && !wr_cnt && !trig && soft_rst_n_i && st.count == COUNT_MAX
    |=> st.flag && st.count == COUNT_CLR && irq_o == st.en
  ) else $error("rollover did not set flag");

  a_stop_hold: assert property (
    !run && !wr_cnt && !trig |=> st.count == $past(st.count)
  ) else $error("count moved while stopped");

  a_bus_answer: assert property (
    take |=> !avs_waitrequest_o ##1 avs_waitrequest_o
  ) else $error("waitrequest not low for one cycle");

  // warm reset idles the bus and drops flag and interrupt
  a_warm_idle: assert property (
    !soft_rst_n_i |=> avs_waitrequest_o && !irq_o && !st.flag
  ) else $error("warm reset left bus or interrupt active");

  // write-one clears the flag unless a rollover lands with it
  a_flag_clear: assert property (
    wr_flags && wbyte[IRQ_OVF_BIT] && !ovf |=> !st.flag
  ) else $error("write one did not clear the overflow flag");

  // a rollover in the clear cycle must still leave the flag set
  a_flag_set_wins: assert property (
    ovf && soft_rst_n_i |=> st.flag
  ) else $error("rollover lost against a flag clear");

  // the pin is a registered copy, so it must agree with its sources
  a_irq_level: assert property (
    irq_o == (st.flag && st.en)
  ) else $error("interrupt level disagrees with flag and enable");

  // one tick moves the count by exactly one, wrapping at the top
  a_cnt_step: assert property (
    inc && !wr_cnt && !trig && soft_rst_n_i
    |=> st.count == $past(st.count) + 16'h0001
  ) else $error("count did not step by one on a tick");

  // without a tick, write or trigger the count must not drift
  a_idle_hold: assert property (
    !inc && !wr_cnt && !trig |=> st.count == $past(st.count)
  ) else $error("count moved without a tick");

endmodule

// file: sim/tmo_xtal_model.sv
// external count clock source standing in for the crystal or pin
`timescale 1ns/100ps

module tmo_xtal_model (
  input wire logic run_i,
  output logic clk_o
);
  // whole periods only, then parked low so no stray edge leaks out
  always begin
    clk_o = 1'b0;
    wait (run_i);
    clk_o = 1'b1;
    #37;
    clk_o = 1'b0;
    #37;
  end
endmodule

// file: sim/testbench.sv
// self-checking bench for the sixteen-bit timer one block
`timescale 1ns/100ps

module testbench;
  import tmo_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, soft_rst_n = 1'b1, xrun = 1'b0;
  logic [1:0] trg = 2'b00;
  logic [31:0] rdata;
  logic ext_clk, xosc, irq, wreq;
  tmo_avs_req_t req = '0;
  int miscompares = 0, comparisons = 0;

  ////////////////////////////////////////////////////////////////////////
  // fast divider so one core cycle is one instruction tick
  tmo_timer #(.INSTR_DIV(1)) dut_u (.core_clk_i(core_clk),
    .arst_n_i(arst_n), .soft_rst_n_i(soft_rst_n), .avs_i(req),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .ext_clk_i(ext_clk), .cmp_trig_a_i(trg[0]), .cmp_trig_b_i(trg[1]),
    .crystal_osc_enable_o(xosc), .irq_o(irq));
  tmo_xtal_model xtal_u (.run_i(xrun), .clk_o(ext_clk));

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_pin(input string nm, input logic e, input logic g);
    check(nm, {31'h0, e}, {31'h0, g});
  endtask

  logic [31:0] rdata_q;

  // one avalon transfer; tr raises trigger a for the commit edge only
  // a slave that never answers is left to the watchdog
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, input logic tr);
    @(posedge core_clk);
    req <= '{read: !wr, write: wr, address: {idx, 2'b00},
             writedata: {24'h00_0000, wd}, byteenable: 4'hf};
    do begin
      @(posedge core_clk);
      if (tr) trg[0] <= wreq;
    end while (wreq !== 1'b0);
    if (!wr) rdata_q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 1'b0);
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx,
                     input logic [7:0] e);
    bus(1'b0, idx, 8'h00, 1'b0);
    check(nm, {24'h00_0000, e}, rdata_q);
  endtask

  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // watchdog; the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    conclude;
  end

  // main test sequence
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    rdc("ctrl", IDX_CTRL, 8'h00);
    rdc("flags", IDX_FLAGS, 8'h00);
    rdc("enables", IDX_ENABLES, 8'h00);
    check_pin("xosc", 1'b0, xosc);
    rdc("unmapped", 8'hff, 8'h00);
    $display("test reset_values done");
    // control mask, crystal pin, warm reset keeps control and count
    wr(IDX_CTRL, 8'hfe);
    rdc("ctrl", IDX_CTRL, 8'h3e);
    check_pin("xosc", 1'b1, xosc);
    wr(IDX_CNT_HI, 8'h12);
    wr(IDX_CNT_LO, 8'h34);
    @(posedge core_clk) soft_rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    soft_rst_n <= 1'b1;
    rdc("ctrl", IDX_CTRL, 8'h3e);
    rdc("cnt_lo", IDX_CNT_LO, 8'h34);
    rdc("cnt_hi", IDX_CNT_HI, 8'h12);
    $display("test warm_reset done");
    // overflow raises flag and irq; mask and write-one clear
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CNT_HI, 8'hff);
    wr(IDX_CNT_LO, 8'hf0);
    wr(IDX_ENABLES, 8'h01);
    wr(IDX_CTRL, 8'h01);
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge core_clk);
    check_pin("irq", 1'b1, irq);
    rdc("flags", IDX_FLAGS, 8'h01);
    wr(IDX_ENABLES, 8'h00);
    repeat (2) @(posedge core_clk);
    check_pin("irq", 1'b0, irq);
    rdc("flags", IDX_FLAGS, 8'h01);
    wr(IDX_FLAGS, 8'h01);
    rdc("flags", IDX_FLAGS, 8'h00);
    $display("test overflow done");
    // both triggers clear the count without touching the flag
    wr(IDX_CTRL, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(IDX_CNT_HI, 8'haa);
      wr(IDX_CNT_LO, 8'h55);
      @(posedge core_clk) trg[k] <= 1'b1;
      @(posedge core_clk) trg[k] <= 1'b0;
      rdc("cnt_lo", IDX_CNT_LO, 8'h00);
      rdc("cnt_hi", IDX_CNT_HI, 8'h00);
      rdc("flags", IDX_FLAGS, 8'h00);
    end
    // a write landing with a trigger wins and the other byte survives
    wr(IDX_CNT_HI, 8'h5a);
    bus(1'b1, IDX_CNT_LO, 8'h77, 1'b1);
    rdc("cnt_lo", IDX_CNT_LO, 8'h77);
    rdc("cnt_hi", IDX_CNT_HI, 8'h5a);
    $display("test trigger done");
    // divide by eight; a fresh write must restart the prescaler phase
    wr(IDX_CNT_HI, 8'h00);
    wr(IDX_CTRL, 8'h31);
    for (int i = 0; i < 4; i++) begin
      repeat (i) @(posedge core_clk);
      wr(IDX_CNT_LO, 8'h10);
      rdc("cnt_lo", IDX_CNT_LO, 8'h10);
      rdc("cnt_lo", IDX_CNT_LO, 8'h10);
    end
    $display("test prescaler done");
    // five edges from the external source, prescale one
    wr(IDX_CTRL, 8'h00);
    wr(IDX_CNT_HI, 8'h00);
    wr(IDX_CNT_LO, 8'h00);
    wr(IDX_CTRL, 8'h03);
    xrun <= 1'b1;
    repeat (5) @(posedge ext_clk);
    xrun <= 1'b0;
    repeat (30) @(posedge core_clk);
    rdc("cnt_lo", IDX_CNT_LO, 8'h05);
    $display("test external_count done");
    // power-on reset mid-run clears control again
    @(posedge core_clk) arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rdc("ctrl", IDX_CTRL, 8'h00);
    $display("test second_reset done");
    conclude;
  end
endmodule
